/* verilog/ssbc_pkg.sv */
package ssbc_pkg;

  // ==========================================================================
  // widths of the array word and its byte lanes
  localparam int unsigned ADDR_W  = 20;
  localparam int unsigned HI_W    = 18;
  localparam int unsigned BURST_W = 2;
  localparam int unsigned LANES   = 4;
  localparam int unsigned LANE_W  = 9;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned WORD_W  = 36;

  // ==========================================================================
  // values after reset and fixed lane patterns
  localparam logic [BURST_W-1:0] BURST_RST  = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
  localparam logic [HI_W-1:0]    HI_RST     = 18'h00000;
  localparam logic [WORD_W-1:0]  WORD_RST   = 36'h000000000;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
  localparam logic [LANES-1:0]   LANES_ALL  = 4'hf;
  localparam logic               SYNC_RST   = 1'h0;

  // ==========================================================================
  // timing: the sleep pin settles through this many flops before it acts
  localparam int unsigned SLEEP_SYNC_CYCLES = 2;

  // ==========================================================================
  // kind of access registered at the last clock rise
  typedef enum logic [1:0] {
    SSBC_IDLE,
    SSBC_READ,
    SSBC_WRITE
  } ssbc_cyc_e;

endpackage

/* verilog/ssbc_burst_ctr.sv */
// two-bit wraparound burst counter, linear or interleaved order
module ssbc_burst_ctr (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         load_i,
  input  wire logic [ssbc_pkg::BURST_W-1:0] start_i,
  input  wire logic                         step_i,
  input  wire logic                         interleave_i,
  output logic      [ssbc_pkg::BURST_W-1:0] addr_o
);

  logic [ssbc_pkg::BURST_W-1:0] base_r;
  logic [ssbc_pkg::BURST_W-1:0] base_nxt;
  logic [ssbc_pkg::BURST_W-1:0] ofs_r;
  logic [ssbc_pkg::BURST_W-1:0] ofs_nxt;
  logic [ssbc_pkg::BURST_W-1:0] addr_r;
  logic [ssbc_pkg::BURST_W-1:0] addr_nxt;
  logic [ssbc_pkg::BURST_W-1:0] ofs_inc;

  // ==========================================================================
  // next counter state: load wins over step, hold otherwise
  always_comb begin
    ofs_inc  = ofs_r + ssbc_pkg::BURST_ONE;
    base_nxt = base_r;
    ofs_nxt  = ofs_r;
    addr_nxt = addr_r;
    if (load_i) begin
      base_nxt = start_i;
      ofs_nxt  = ssbc_pkg::BURST_RST;
      addr_nxt = start_i;
    end else if (step_i) begin
      ofs_nxt = ofs_inc;
      // interleaved order xors the step count into the start address
      addr_nxt = interleave_i ? (base_r ^ ofs_inc) : (base_r + ofs_inc);
    end
  end

  // ==========================================================================
  // counter registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      base_r <= ssbc_pkg::BURST_RST;
      ofs_r  <= ssbc_pkg::BURST_RST;
      addr_r <= ssbc_pkg::BURST_RST;
    end else begin
      base_r <= base_nxt;
      ofs_r  <= ofs_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign addr_o = addr_r;

endmodule

/* verilog/ssbc_cycle_ctrl.sv */
// Functional notes
// - controller strobe with a failing chip select, or processor strobe with second or third select failing, gives a deselect cycle, data pins released
// - while asleep, no address is used, controls ignored, data pins released
// - all selects active and processor strobe low start a burst read
// - controller strobe start with write decoded starts a burst write, capturing data
// - controller strobe start with read decoded starts a burst read
// - no strobe and burst step low advance the counter, read or write
// - no strobe and burst step high repeat the current address
// - processor strobe is ignored while the primary select is high
// - write when global write low, or qualifier low with any lane low
// - read when global write high and qualifier high or all lanes high
// - output enable acts without the clock and is masked during writes
// - in a read, output enable low drives all bits, high releases them
// - qualifier low, global write high: write exactly the lanes whose enable is low
// - global write low writes all four lanes
// - two-bit counter from address bits, linear or interleaved by order select
// - sleep takes two clocks to enter or leave; master deselects around it
module ssbc_cycle_ctrl (
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic [ssbc_pkg::ADDR_W-1:0] address_i,
  input  wire logic                        chip_sel_primary_n_i,
  input  wire logic                        chip_sel_second_i,
  input  wire logic                        chip_sel_third_n_i,
  input  wire logic                        sleep_request_i,
  input  wire logic                        processor_strobe_n_i,
  input  wire logic                        controller_strobe_n_i,
  input  wire logic                        burst_step_n_i,
  input  wire logic                        global_write_n_i,
  input  wire logic                        byte_write_qualifier_n_i,
  input  wire logic                        lane_a_write_n_i,
  input  wire logic                        lane_b_write_n_i,
  input  wire logic                        lane_c_write_n_i,
  input  wire logic                        lane_d_write_n_i,
  input  wire logic                        output_enable_n_i,
  input  wire logic                        order_select_i,
  input  wire logic [ssbc_pkg::DATA_W-1:0] data_io_i,
  output logic      [ssbc_pkg::DATA_W-1:0] data_io_o,
  output logic                             data_io_oe_o,
  input  wire logic [ssbc_pkg::LANES-1:0]  parity_io_i,
  output logic      [ssbc_pkg::LANES-1:0]  parity_io_o,
  output logic                             parity_io_oe_o,
  output logic      [ssbc_pkg::ADDR_W-1:0] core_addr_o,
  output logic      [ssbc_pkg::LANES-1:0]  core_lane_we_o,
  output logic      [ssbc_pkg::WORD_W-1:0] core_wdata_o,
  input  wire logic [ssbc_pkg::WORD_W-1:0] core_rdata_i,
  output logic                             sleeping_o,
  output logic                             burst_active_o
);

  // ==========================================================================
  // state
  ssbc_pkg::ssbc_cyc_e             cyc_r;
  ssbc_pkg::ssbc_cyc_e             cyc_nxt;
  logic [ssbc_pkg::HI_W-1:0]       hi_r;
  logic [ssbc_pkg::HI_W-1:0]       hi_nxt;
  logic [ssbc_pkg::LANES-1:0]      lanes_r;
  logic [ssbc_pkg::LANES-1:0]      lanes_nxt;
  logic [ssbc_pkg::WORD_W-1:0]     wdata_r;
  logic [ssbc_pkg::WORD_W-1:0]     wdata_nxt;
  logic                            burst_r;
  logic                            burst_nxt;
  logic                            slp_s1_r;
  logic                            slp_s2_r;
  logic                            ord_s1_r;
  logic                            ord_s2_r;

  // decode terms
  logic [ssbc_pkg::LANES-1:0]      lane_n;
  logic [ssbc_pkg::LANES-1:0]      lane_sel;
  logic [ssbc_pkg::WORD_W-1:0]     pin_word;
  logic [ssbc_pkg::BURST_W-1:0]    burst_addr;
  logic                            sel_all;
  logic                            p_start;
  logic                            c_start;
  logic                            wr_any;
  logic                            ctr_load;
  logic                            ctr_step;

  assign lane_n = {lane_d_write_n_i, lane_c_write_n_i, lane_b_write_n_i, lane_a_write_n_i};

  // ==========================================================================
  // lane packing: each lane is eight data bits plus its parity bit
  for (genvar k = 0; k < ssbc_pkg::LANES; k++) begin : g_lane
    assign pin_word[k*ssbc_pkg::LANE_W +: ssbc_pkg::LANE_W] = {parity_io_i[k], data_io_i[k*8 +: 8]};
    assign data_io_o[k*8 +: 8] = core_rdata_i[k*ssbc_pkg::LANE_W +: 8];
    assign parity_io_o[k]      = core_rdata_i[k*ssbc_pkg::LANE_W + 8];
  end

  // ==========================================================================
  // write decode from global write, qualifier and lane enables
  always_comb begin
    wr_any = !global_write_n_i || (!byte_write_qualifier_n_i && !(&lane_n));
    if (!global_write_n_i) begin
      lane_sel = ssbc_pkg::LANES_ALL;
    end else if (!byte_write_qualifier_n_i) begin
      lane_sel = ~lane_n;
    end else begin
      lane_sel = ssbc_pkg::LANES_NONE;
    end
  end

  // ==========================================================================
  // cycle decode at each clock rise
  always_comb begin
    sel_all   = !chip_sel_primary_n_i && chip_sel_second_i && !chip_sel_third_n_i;
    // processor strobe counts only while the primary select is low
    p_start   = !chip_sel_primary_n_i && !processor_strobe_n_i;
    c_start   = !controller_strobe_n_i && !p_start;
    cyc_nxt   = ssbc_pkg::SSBC_IDLE;
    hi_nxt    = hi_r;
    lanes_nxt = ssbc_pkg::LANES_NONE;
    wdata_nxt = wdata_r;
    burst_nxt = burst_r;
    ctr_load  = 1'b0;
    ctr_step  = 1'b0;
    if (slp_s2_r) begin
      // asleep: nothing sampled, pending burst dropped
      burst_nxt = 1'b0;
    end else if (p_start || c_start) begin
      if (sel_all) begin
        ctr_load  = 1'b1;
        burst_nxt = 1'b1;
        hi_nxt    = address_i[ssbc_pkg::ADDR_W-1:ssbc_pkg::BURST_W];
        if (p_start || !wr_any) begin
          cyc_nxt = ssbc_pkg::SSBC_READ;
        end else begin
          cyc_nxt   = ssbc_pkg::SSBC_WRITE;
          lanes_nxt = lane_sel;
          wdata_nxt = pin_word;
        end
      end else begin
        burst_nxt = 1'b0;
      end
    end else if (burst_r) begin
      // no strobe: advance or hold the burst, direction from write decode
      ctr_step = !burst_step_n_i;
      if (wr_any) begin
        cyc_nxt   = ssbc_pkg::SSBC_WRITE;
        lanes_nxt = lane_sel;
        wdata_nxt = pin_word;
      end else begin
        cyc_nxt = ssbc_pkg::SSBC_READ;
      end
    end
  end

  // ==========================================================================
  // cycle registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cyc_r   <= ssbc_pkg::SSBC_IDLE;
      hi_r    <= ssbc_pkg::HI_RST;
      lanes_r <= ssbc_pkg::LANES_NONE;
      wdata_r <= ssbc_pkg::WORD_RST;
      burst_r <= 1'b0;
    end else begin
      cyc_r   <= cyc_nxt;
      hi_r    <= hi_nxt;
      lanes_r <= lanes_nxt;
      wdata_r <= wdata_nxt;
      burst_r <= burst_nxt;
    end
  end

  // ==========================================================================
  // sleep and order pins are not tied to the clock, so two flops each;
  // the two-stage delay is also the enter and leave time of sleep
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slp_s1_r <= ssbc_pkg::SYNC_RST;
      slp_s2_r <= ssbc_pkg::SYNC_RST;
      ord_s1_r <= ssbc_pkg::SYNC_RST;
      ord_s2_r <= ssbc_pkg::SYNC_RST;
    end else begin
      slp_s1_r <= sleep_request_i;
      slp_s2_r <= slp_s1_r;
      ord_s1_r <= order_select_i;
      ord_s2_r <= ord_s1_r;
    end
  end

  // ==========================================================================
  // burst counter
  ssbc_burst_ctr u_ctr (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .load_i       (ctr_load),
    .start_i      (address_i[ssbc_pkg::BURST_W-1:0]),
    .step_i       (ctr_step),
    .interleave_i (ord_s2_r),
    .addr_o       (burst_addr)
  );

  // ==========================================================================
  // array side; writes stop at once when sleep takes hold
  assign core_addr_o    = {hi_r, burst_addr};
  assign core_lane_we_o = slp_s2_r ? ssbc_pkg::LANES_NONE : lanes_r;
  assign core_wdata_o   = wdata_r;
  assign sleeping_o     = slp_s2_r;
  assign burst_active_o = burst_r;

  // output enable is not sampled: the pad follows the pin within the period,
  // masked whenever the registered cycle is not a read
  assign data_io_oe_o   = (cyc_r == ssbc_pkg::SSBC_READ) && !output_enable_n_i && !slp_s2_r;
  assign parity_io_oe_o = data_io_oe_o;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic awake;
  assign awake = !slp_s2_r;

  desel_cycle_a: assert property (
    (awake && !controller_strobe_n_i && chip_sel_primary_n_i) |=> (cyc_r == ssbc_pkg::SSBC_IDLE) && !burst_r
  ) else $error("deselect strobe did not idle the cycle");

  sleep_quiet_a: assert property (
    slp_s2_r |-> !data_io_oe_o && (core_lane_we_o == ssbc_pkg::LANES_NONE)
  ) else $error("pins or array active while asleep");

  proc_read_a: assert property (
    (awake && sel_all && !processor_strobe_n_i)
      |=> (cyc_r == ssbc_pkg::SSBC_READ) && (core_addr_o == $past(address_i))
  ) else $error("processor start did not begin a read at the pin address");

  ctrl_write_a: assert property (
    (awake && sel_all && processor_strobe_n_i && !controller_strobe_n_i && wr_any)
      |=> (cyc_r == ssbc_pkg::SSBC_WRITE) && (core_wdata_o == $past(pin_word))
  ) else $error("controller write start wrong");

  ctrl_read_a: assert property (
    (awake && sel_all && processor_strobe_n_i && !controller_strobe_n_i && !wr_any)
      |=> (cyc_r == ssbc_pkg::SSBC_READ) && (core_lane_we_o == ssbc_pkg::LANES_NONE)
  ) else $error("controller read start wrong");

  burst_advance_a: assert property (
    (awake && burst_r && !p_start && controller_strobe_n_i && !burst_step_n_i && !ord_s2_r)
      |=> core_addr_o[1:0] == $past(core_addr_o[1:0]) + 2'h1
  ) else $error("linear burst did not advance by one");

  burst_hold_a: assert property (
    (awake && burst_r && !p_start && controller_strobe_n_i && burst_step_n_i)
      |=> $stable(core_addr_o) && (cyc_r != ssbc_pkg::SSBC_IDLE)
  ) else $error("suspend moved the address");

  proc_ignore_a: assert property (
    (awake && burst_r && chip_sel_primary_n_i && controller_strobe_n_i && !processor_strobe_n_i)
      |=> burst_r && (cyc_r != ssbc_pkg::SSBC_IDLE)
  ) else $error("processor strobe acted with primary select high");

  oe_mask_a: assert property (
    (cyc_r == ssbc_pkg::SSBC_WRITE) |-> !data_io_oe_o && !parity_io_oe_o
  ) else $error("data driven during a write");

  read_drive_a: assert property (
    (cyc_r == ssbc_pkg::SSBC_READ && awake && !output_enable_n_i) |-> data_io_oe_o
  ) else $error("read with enable low left pins released");

  lane_select_a: assert property (
    (awake && burst_r && !p_start && controller_strobe_n_i && global_write_n_i && !byte_write_qualifier_n_i)
      |=> core_lane_we_o == ~$past(lane_n)
  ) else $error("byte lanes written do not match enables");

  global_all_a: assert property (
    (awake && burst_r && !p_start && controller_strobe_n_i && !global_write_n_i)
      |=> core_lane_we_o == ssbc_pkg::LANES_ALL
  ) else $error("global write missed a lane");

  sleep_entry_a: assert property (
    (!sleep_request_i ##1 sleep_request_i [*2]) |=> slp_s2_r && !$past(slp_s2_r)
  ) else $error("sleep entry not two clocks");

  sleep_exit_a: assert property (
    (sleep_request_i ##1 (!sleep_request_i) [*2]) |=> !slp_s2_r && $past(slp_s2_r)
  ) else $error("sleep exit not two clocks");

  sleep_ignore_a: assert property (
    slp_s2_r |=> (cyc_r == ssbc_pkg::SSBC_IDLE) && !burst_r
  ) else $error("cycle or burst taken while asleep");

  read_release_a: assert property (
    (cyc_r == ssbc_pkg::SSBC_READ && output_enable_n_i) |-> !data_io_oe_o && !parity_io_oe_o
  ) else $error("read with enable high still drove pins");

  cont_wdata_a: assert property (
    (awake && burst_r && !p_start && controller_strobe_n_i && wr_any)
      |=> core_wdata_o == $past(pin_word)
  ) else $error("continue write did not latch pin data");

  cov_write_burst: cover property (cyc_r == ssbc_pkg::SSBC_WRITE ##1 cyc_r == ssbc_pkg::SSBC_WRITE);
  cov_read_drive:  cover property (cyc_r == ssbc_pkg::SSBC_READ && data_io_oe_o);
  cov_sleep_wake:  cover property (slp_s2_r ##1 !slp_s2_r);
  cov_interleave:  cover property (burst_r && ord_s2_r && ctr_step);
  cov_deselect:    cover property (awake && (p_start || c_start) && !sel_all);

endmodule

/* dv/ssbc_array_model.sv */
// ==========================================================================
// array model behind the block: combinational read, lane writes at the rise
module ssbc_array_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [3:0]  lane_we_i,
  input  wire logic [35:0] wdata_i,
  output logic      [35:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [35:0] mem [16];

  // no clock on the read path, so data shows in the registered period
  assign rdata_o = mem[addr_i];

  // distinct contents so a read proves which word was addressed
  initial begin
    for (int i = 0; i < 16; i++)
      mem[i] = 36'h95a5a5a00 + 36'(i);
  end

  // only enabled lanes change, the rest keep their old bits
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++)
      if (lane_we_i[k]) mem[addr_i][9*k+:9] <= wdata_i[9*k+:9];
  end
endmodule

/* dv/sync_burst_sram_cycle_control_bench.sv */
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module sync_burst_sram_cycle_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [35:0] D1 = 36'h912345678;
  localparam logic [35:0] D2 = 36'h6cafebeef;
  localparam logic [35:0] M  = 36'h007fc01ff;

  // ctl = {sleep, oe_n, sel1_n, sel2, sel3_n, pstb_n, cstb_n, step_n, all_wr_n, qual_n}
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic [9:0]  ctl     = 10'h0bf;
  logic [3:0]  lanes_n = 4'hf;
  logic [19:0] addr    = 20'h00000;
  logic [35:0] dbus    = 36'h000000000;
  logic        ord     = 1'b0;
  logic [31:0] dq_o;
  logic        dq_oe;
  logic [3:0]  par_o;
  logic        par_oe;
  logic [31:0] dq_w;
  logic [3:0]  par_w;
  logic [19:0] core_addr;
  logic [3:0]  core_we;
  logic [35:0] core_wdata;
  logic [35:0] core_rdata;
  logic        sleeping;
  logic        burst_act;
  int          fail_count  = 0;
  int          checks_done = 0;

  always #12.5 clk_i = ~clk_i;

  // the shared pins carry the device's value whenever it drives them
  assign dq_w  = dq_oe ? dq_o : dbus[31:0];
  assign par_w = par_oe ? par_o : dbus[35:32];

  ssbc_cycle_ctrl uut (
    .clk_i(clk_i), .reset_i(reset_i), .address_i(addr),
    .chip_sel_primary_n_i(ctl[7]), .chip_sel_second_i(ctl[6]), .chip_sel_third_n_i(ctl[5]),
    .sleep_request_i(ctl[9]), .processor_strobe_n_i(ctl[4]), .controller_strobe_n_i(ctl[3]),
    .burst_step_n_i(ctl[2]), .global_write_n_i(ctl[1]), .byte_write_qualifier_n_i(ctl[0]),
    .lane_a_write_n_i(lanes_n[0]), .lane_b_write_n_i(lanes_n[1]),
    .lane_c_write_n_i(lanes_n[2]), .lane_d_write_n_i(lanes_n[3]),
    .output_enable_n_i(ctl[8]), .order_select_i(ord),
    .data_io_i(dq_w), .data_io_o(dq_o), .data_io_oe_o(dq_oe),
    .parity_io_i(par_w), .parity_io_o(par_o), .parity_io_oe_o(par_oe),
    .core_addr_o(core_addr), .core_lane_we_o(core_we), .core_wdata_o(core_wdata),
    .core_rdata_i(core_rdata), .sleeping_o(sleeping), .burst_active_o(burst_act)
  );

  ssbc_array_model array (
    .clk_i(clk_i), .addr_i(core_addr[3:0]), .lane_we_i(core_we),
    .wdata_i(core_wdata), .rdata_o(core_rdata)
  );

  // ==========================================================================
  // helpers: {parity, data} to lane packing and back, model contents
  function automatic logic [35:0] pk(input logic [35:0] d);
    for (int k = 0; k < 4; k++) pk[9*k+:9] = {d[32+k], d[8*k+:8]};
  endfunction

  function automatic logic [35:0] dq(input logic [35:0] w);
    for (int k = 0; k < 4; k++) {dq[32+k], dq[8*k+:8]} = w[9*k+:9];
  endfunction

  function automatic logic [35:0] ini(input int i);
    return 36'h95a5a5a00 + 36'(i);
  endfunction

  // one bus period: drive at the rise, look at the fall; what shows then
  // is the answer to the period driven by the previous call
  task automatic s(input logic [9:0] c, input logic [3:0] l = 4'hf,
                   input logic [19:0] a = 20'h00000, input logic [35:0] d = 36'h000000000);
    @(posedge clk_i);
    ctl     <= c;
    lanes_n <= l;
    addr    <= a;
    dbus    <= d;
    @(negedge clk_i);
  endtask

  task automatic see(input logic [19:0] a, input logic [3:0] we, input logic oe);
    `CHK(core_addr, a)
    `CHK(core_we, we)
    `CHK(dq_oe, oe)
    `CHK(par_oe, oe)
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_read();
    s(10'h04d, 4'hf, 20'h00013); // processor start with global write low still reads
    s(10'h0bb);
    see(20'h00013, 4'h0, 1'b1);
    `CHK({par_o, dq_o}, dq(ini(3)))
    `CHK(burst_act, 1'b1)
    s(10'h0bb);
    see(20'h00010, 4'h0, 1'b1);
    s(10'h1bf);
    see(20'h00011, 4'h0, 1'b0);
    s(10'h0bf);
    see(20'h00011, 4'h0, 1'b1);
    `CHK({par_o, dq_o}, dq(ini(1)))
  endtask

  task automatic t_write();
    s(10'h155, 4'hf, 20'h00105, D1);
    s(10'h0ba, 4'ha, 20'h00000, D2);
    see(20'h00105, 4'hf, 1'b0);
    `CHK(core_wdata, pk(D1))
    s(10'h0be);
    see(20'h00106, 4'h5, 1'b0);
    `CHK(core_wdata & M, pk(D2) & M)
    s(10'h057, 4'hf, 20'h00105);
    see(20'h00106, 4'h0, 1'b1);
    `CHK({par_o, dq_o}, dq((ini(6) & ~M) | (pk(D2) & M)))
    s(10'h0bf);
    see(20'h00105, 4'h0, 1'b1);
    `CHK({par_o, dq_o}, D1)
    s(10'h1bf);
    s(10'h1b9, 4'hf, 20'h00000, D2);
    s(10'h1bf);
    see(20'h00106, 4'hf, 1'b0);
    `CHK(core_wdata, pk(D2))
  endtask

  task automatic t_desel();
    s(10'h0d5, 4'hf, 20'h00200, D1);
    s(10'h00f, 4'hf, 20'h00300);
    `CHK(core_we, 4'h0)
    `CHK(dq_oe, 1'b0)
    `CHK(burst_act, 1'b0)
    s(10'h0bb);
    `CHK(dq_oe, 1'b0)
    s(10'h0bf);
    `CHK(dq_oe, 1'b0)
  endtask

  task automatic t_order();
    @(posedge clk_i);
    ord <= 1'b1;
    repeat (3) s(10'h0bf);
    s(10'h04f, 4'hf, 20'h00031);
    s(10'h0ab);
    see(20'h00031, 4'h0, 1'b1);
    s(10'h0ab);
    see(20'h00030, 4'h0, 1'b1);
    s(10'h0bf);
    see(20'h00033, 4'h0, 1'b1);
  endtask

  task automatic t_sleep();
    s(10'h2bf);
    s(10'h2bf);
    `CHK(sleeping, 1'b0)
    s(10'h2bf);
    `CHK(sleeping, 1'b1)
    s(10'h255, 4'hf, 20'h00105, 36'h000000000);
    s(10'h24f, 4'hf, 20'h00105);
    `CHK(core_we, 4'h0)
    s(10'h0bf);
    `CHK(dq_oe, 1'b0)
    `CHK(burst_act, 1'b0)
    s(10'h0bf);
    `CHK(sleeping, 1'b1)
    s(10'h0bf);
    `CHK(sleeping, 1'b0)
    s(10'h04f, 4'hf, 20'h00105);
    s(10'h0bf);
    `CHK({par_o, dq_o}, D1)
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_read();
    t_write();
    t_desel();
    t_order();
    t_sleep();
    print_verdict();
  end
endmodule
